//--- design/gpio_qual_regs.vh
// Constants for the input qualifier and idle wake timing block
`ifndef GPIO_QUAL_REGS_VH
`define GPIO_QUAL_REGS_VH
`define GROUP_PINS 8
`define PERIOD_DIV_MAX 8'hFF
`define SAMPLES_SHORT 3
`define SAMPLES_LONG 6
`define WINDOW_SHORT 2
`define WINDOW_LONG 5
`define RESUME_FAST_CYCLES 20
`define RESUME_SLOW_CYCLES 1050
`define STANDBY_QUAL_WIDTH 6
`define SYNC_MIN_CYCLES 2
`endif

//--- design/pin_qualifier.v
// One pin input qualifier: sample history and level decision
`include "gpio_qual_regs.vh"
module pin_qualifier (
	// Clock and reset
	input wire clock,
	input wire reset,
	// Sampling
	input wire sample_tick,
	input wire six_samples,
	input wire pin_in,
	// Result
	output reg pin_qualified
);
	reg [`SAMPLES_LONG-1:0] history;
	wire [`SAMPLES_LONG-1:0] next_history;
	wire all_high;
	wire all_low;
	assign next_history = {history[`SAMPLES_LONG-2:0], pin_in};
	// Window is three or six newest samples
	assign all_high = six_samples ? (&next_history) :
		(&next_history[`SAMPLES_SHORT-1:0]);
	assign all_low = six_samples ? ~(|next_history) :
		~(|next_history[`SAMPLES_SHORT-1:0]);
	always @(posedge clock) begin
		if (reset) begin
			history <= {`SAMPLES_LONG{1'b0}};
			pin_qualified <= 1'b0;
		end else if (sample_tick) begin
			history <= next_history;
			// Glitches leave the output untouched
			if (all_high && !pin_qualified)
				pin_qualified <= 1'b1;
			else if (all_low && pin_qualified)
				pin_qualified <= 1'b0;
		end
	end
endmodule // pin_qualifier

//--- design/gpio_input_qualifier_wake.v
// Group input qualifier with idle-mode wake and resume timing
`include "gpio_qual_regs.vh"
module gpio_input_qualifier_wake #(
	parameter GROUPS = 2,
	parameter RESUME_SLOW = `RESUME_SLOW_CYCLES
) (
	// Clock and reset
	input wire clock,
	input wire reset,
	// Pins and qualifier configuration
	input wire [GROUPS*`GROUP_PINS-1:0] gpio_in,
	input wire [GROUPS*8-1:0] sample_period_divider,
	input wire [GROUPS*`GROUP_PINS-1:0] qual_sample_select_reg,
	// Low-power control
	input wire [`STANDBY_QUAL_WIDTH-1:0] standby_qual_count,
	input wire idle_enter,
	input wire flash_sleeping,
	// Wake sources
	input wire [GROUPS*`GROUP_PINS-1:0] wake_pin_enable,
	input wire interrupt_pending,
	input wire watchdog_interrupt,
	input wire external_nmi_pin,
	input wire external_reset_pin_n,
	// Results
	output reg [GROUPS*`GROUP_PINS-1:0] gpio_qualified,
	output reg [GROUPS-1:0] sample_strobe,
	output reg idle_active,
	output reg resume_pulse,
	output reg [`STANDBY_QUAL_WIDTH-1:0] standby_qual_out
);
	localparam NPINS = GROUPS*`GROUP_PINS;
	localparam ST_RUN = 2'd0;
	localparam ST_IDLE = 2'd1;
	localparam ST_RESUME = 2'd2;
	localparam [10:0] FAST = `RESUME_FAST_CYCLES;
	localparam [10:0] SLOW = RESUME_SLOW;

	wire [NPINS-1:0] qual_raw;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [10:0] resume_count;
	reg [10:0] next_resume_count;
	reg wake_any;
	reg [NPINS-1:0] qual_prev;
	integer k;

	// Terminal count for a divider: 0 means every cycle, else 2n-1 (a period of 2n cycles)
	function [8:0] period_last;
		input [7:0] div;
		begin
			if (div == 8'h00)
				period_last = 9'h000;
			else
				period_last = {div, 1'b0} - 9'h001;
		end
	endfunction

	genvar g;
	genvar p;
	generate
		for (g = 0; g < GROUPS; g = g + 1) begin : grp
			reg [8:0] div_count;
			wire [7:0] div_value;
			assign div_value = sample_period_divider[g*8 +: 8];
			// Shared sampling divider per eight-pin group
			always @(posedge clock) begin
				if (reset) begin
					div_count <= 9'h000;
					sample_strobe[g] <= 1'b0;
				end else if (div_count >= period_last(div_value)) begin
					div_count <= 9'h000;
					sample_strobe[g] <= 1'b1;
				end else begin
					div_count <= div_count + 9'h001;
					sample_strobe[g] <= 1'b0;
				end
			end
			for (p = 0; p < `GROUP_PINS; p = p + 1) begin : pin
				pin_qualifier u_qual (
					.clock(clock),
					.reset(reset),
					.sample_tick(div_count >= period_last(div_value)),
					.six_samples(qual_sample_select_reg[g*`GROUP_PINS+p]),
					.pin_in(gpio_in[g*`GROUP_PINS+p]),
					.pin_qualified(qual_raw[g*`GROUP_PINS+p])
				);
			end
		end
	endgenerate

	// Registered copies of qualified levels
	always @(posedge clock) begin
		if (reset) begin
			gpio_qualified <= {NPINS{1'b0}};
			qual_prev <= {NPINS{1'b0}};
			standby_qual_out <= {`STANDBY_QUAL_WIDTH{1'b0}};
		end else begin
			gpio_qualified <= qual_raw;
			qual_prev <= gpio_qualified;
			standby_qual_out <= standby_qual_count;
		end
	end

	// Wake event: qualified edge on a wake-enabled pin or any listed source
	always @* begin
		wake_any = interrupt_pending | watchdog_interrupt |
			external_nmi_pin | ~external_reset_pin_n;
		for (k = 0; k < NPINS; k = k + 1)
			if (wake_pin_enable[k] && gpio_qualified[k] != qual_prev[k])
				wake_any = 1'b1;
	end

	// Idle / resume sequencing
	always @* begin
		next_state = state;
		next_resume_count = resume_count;
		case (state)
			ST_RUN: begin
				if (idle_enter)
					next_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (wake_any) begin
					next_state = ST_RESUME;
					// Qualifier delay is already spent before wake_any
					next_resume_count = (flash_sleeping ? SLOW : FAST)
						- 11'd2;
				end
			end
			ST_RESUME: begin
				if (resume_count == 11'd0)
					next_state = ST_RUN;
				else
					next_resume_count = resume_count - 11'd1;
			end
			default: next_state = ST_RUN;
		endcase
	end

	always @(posedge clock) begin
		if (reset) begin
			state <= ST_RUN;
			resume_count <= 11'd0;
			idle_active <= 1'b0;
			resume_pulse <= 1'b0;
		end else begin
			state <= next_state;
			resume_count <= next_resume_count;
			idle_active <= (next_state != ST_RUN);
			resume_pulse <= (state == ST_RESUME) &&
				(next_state == ST_RUN);
		end
	end
endmodule // gpio_input_qualifier_wake

//--- verif/gpio_source.sv
// External source driving the input pins
module gpio_source (
	input wire logic clock,
	output logic [15:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pins = 16'h0000;
	// Hold a level for n cycles
	task automatic drive(input logic [15:0] v, input int n);
		@(negedge clock) pins = v;
		repeat (n - 1) @(negedge clock);
	endtask
endmodule // gpio_source

//--- verif/gpio_qual_checker_assertions.sv
// Checker on the qualifier and wake ports
module gpio_qual_checker #(
	parameter GROUPS = 2,
	parameter RESUME_SLOW = 30
) (
	// Clock and reset
	input wire logic clock, reset,
	// Inputs
	input wire logic [GROUPS*8-1:0] gpio_in, sample_period_divider,
	input wire logic [GROUPS*8-1:0] qual_sample_select_reg,
	input wire logic [5:0] standby_qual_count,
	input wire logic idle_enter, flash_sleeping, interrupt_pending,
	input wire logic watchdog_interrupt, external_nmi_pin,
	input wire logic external_reset_pin_n,
	// Outputs
	input wire logic [GROUPS*8-1:0] gpio_qualified,
	input wire logic [GROUPS-1:0] sample_strobe,
	input wire logic idle_active, resume_pulse,
	input wire logic [5:0] standby_qual_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire wake = interrupt_pending | watchdog_interrupt | external_nmi_pin
		| !external_reset_pin_n;
	property p_div0; sample_strobe[0] && sample_period_divider[7:0] == 8'h00
		|=> sample_strobe[0]; endproperty
	a_div0: assert property (p_div0) else $error("gap");
	property p_div2; sample_strobe[1] && sample_period_divider[15:8] == 8'h02
		|=> !sample_strobe[1] [*3] ##1 sample_strobe[1]; endproperty
	a_div2: assert property (p_div2) else $error("period");
	property p_hold; $changed(gpio_qualified[7:0]) |-> sample_strobe[0];
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_three; $rose(gpio_qualified[0]) |-> $past(gpio_in[0])
		&& $past(gpio_in[0], 2) && $past(gpio_in[0], 3); endproperty
	a_three: assert property (p_three) else $error("three");
	property p_idle; idle_enter && !idle_active |=> idle_active; endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_fast; $rose(wake) && idle_active && !flash_sleeping
		|-> ##20 resume_pulse; endproperty
	a_fast: assert property (p_fast) else $error("fast");
	property p_slow; $rose(wake) && idle_active && flash_sleeping
		|-> ##30 resume_pulse; endproperty
	a_slow: assert property (p_slow) else $error("slow");
	property p_res; resume_pulse |-> !idle_active && $past(idle_active);
	endproperty
	a_res: assert property (p_res) else $error("resume");
	property p_sq; $stable(standby_qual_count)
		|=> standby_qual_out == $past(standby_qual_count); endproperty
	a_sq: assert property (p_sq) else $error("count");
endmodule // gpio_qual_checker

//--- verif/test_gpio_input_qualifier_wake.sv
// Bench for the group qualifier and idle wake block
`include "gpio_qual_regs.vh"
module test_gpio_input_qualifier_wake;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, reset = 1, idle_enter = 0, flash_sleeping = 0;
	logic [3:0] src = 4'h0;
	logic [15:0] wake_en = 16'h0000;
	wire [15:0] gpio_in, gpio_qualified;
	wire [1:0] sample_strobe;
	wire idle_active, resume_pulse;
	wire [5:0] sq_out;
	int failures = 0, n_tests = 0, n;
	always #20 clock = ~clock;
	gpio_source u_gpio_source (.clock(clock), .pins(gpio_in));
	gpio_input_qualifier_wake #(.GROUPS(2), .RESUME_SLOW(30))
		u_gpio_input_qualifier_wake (.clock(clock), .reset(reset),
		.gpio_in(gpio_in), .sample_period_divider(16'h0200),
		.qual_sample_select_reg(16'h0002), .standby_qual_count(6'h2A),
		.idle_enter(idle_enter), .flash_sleeping(flash_sleeping),
		.wake_pin_enable(wake_en), .interrupt_pending(src[0]),
		.watchdog_interrupt(src[1]), .external_nmi_pin(src[2]),
		.external_reset_pin_n(!src[3]), .gpio_qualified(gpio_qualified),
		.sample_strobe(sample_strobe), .idle_active(idle_active),
		.resume_pulse(resume_pulse), .standby_qual_out(sq_out));
	task chk(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (failures == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Idle entry, wake from one source, count to resume
	task wake(input int s, input int exp);
		@(negedge clock) idle_enter = 1;
		@(negedge clock) idle_enter = 0;
		repeat (4) @(negedge clock);
		chk(idle_active, 1);
		src[s] = 1;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (!resume_pulse && n < 2000);
		src = 4'h0;
		chk(n[15:0], exp[15:0]);
	endtask
	initial begin
		repeat (2) @(negedge clock);
		reset = 0;
		u_gpio_source.drive(16'h0103, 2);
		u_gpio_source.drive(16'h0000, 10);
		chk(gpio_qualified, 16'h0000);
		u_gpio_source.drive(16'h0103, 5);
		chk(gpio_qualified, 16'h0001);
		u_gpio_source.drive(16'h0103, 16);
		chk(gpio_qualified, 16'h0103);
		u_gpio_source.drive(16'h0000, 5);
		chk(gpio_qualified, 16'h0102);
		u_gpio_source.drive(16'h0000, 20);
		chk(gpio_qualified, 16'h0000);
		chk(sq_out, 16'h002A);
		for (int s = 0; s < 4; s++) wake(s, `RESUME_FAST_CYCLES);
		flash_sleeping = 1;
		wake(1, 30);
		stop_test;
	end
	initial begin
		#100000;
		failures++;
		stop_test;
	end
endmodule // test_gpio_input_qualifier_wake
bind gpio_input_qualifier_wake gpio_qual_checker #(.GROUPS(GROUPS),
	.RESUME_SLOW(RESUME_SLOW)) u_gpio_qual_checker (.*);
